// ==== design/sfs_pkg.sv ====
// constants and types for the serial flash status write and read block
package sfs_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SFS_CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] SFS_CMD_READ         = 8'h03;
  localparam logic [7:0] SFS_CMD_FAST_READ    = 8'h0B;
  localparam logic [7:0] SFS_CMD_LOCK_READ    = 8'hE8;
  localparam logic [7:0] SFS_CMD_READ_STATUS  = 8'h05;

  // ----------------------------------------------------------------
  // status register layout and reset values
  // ----------------------------------------------------------------
  localparam int SFS_SR_BUSY = 0;
  localparam int SFS_SR_LATCH = 1;
  localparam int SFS_SR_PL0   = 2;
  localparam int SFS_SR_PL1   = 3;
  localparam int SFS_SR_WDIS  = 7;
  localparam logic       SFS_RST_WDIS = 1'h0;
  localparam logic [1:0] SFS_RST_BP   = 2'h0;
  localparam logic [7:0] SFS_SR_READ_MASK = 8'h8F;

  // ----------------------------------------------------------------
  // frame bit counts (bits already received before the current edge)
  // ----------------------------------------------------------------
  localparam logic [5:0] SFS_WSR_LAST_BIT  = 6'h0F;
  localparam logic [5:0] SFS_ADDR_LAST_BIT = 6'h1F;
  localparam logic [5:0] SFS_TOTAL_MAX     = 6'h3F;
  localparam logic [2:0] SFS_BYTE_LAST     = 3'h7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SFS_CLK_HZ             = 20000000;
  localparam int SFS_STATUS_WRITE_TIME_US = 15000;
  localparam int SFS_STATUS_WRITE_CYCLES  = SFS_STATUS_WRITE_TIME_US * (SFS_CLK_HZ / 1000000);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {SFS_IDLE, SFS_WRITING} sfs_core_state_t;
  typedef enum logic [2:0] {SFS_PH_CMD, SFS_PH_ADDR, SFS_PH_DUMMY, SFS_PH_DATA, SFS_PH_WDATA,
                            SFS_PH_IGNORE} sfs_phase_t;
  typedef enum logic [1:0] {SFS_SRC_ARRAY, SFS_SRC_LOCK, SFS_SRC_STATUS} sfs_src_t;

  typedef struct packed {
    logic            sel_s1;
    logic            sel_s2;
    logic            sel_s3;
    logic            wp_s1;
    logic            wp_s2;
    sfs_core_state_t state;
    logic [23:0]     cnt;
    logic            pend_wdis;
    logic [1:0]      pend_bp;
    logic            wdis;
    logic [1:0]      bp;
    logic            latch;
    logic            wr_busy;
    logic            busy;
    logic            hw_prot;
    logic            res_clr;
  } sfs_core_t;

  typedef struct packed {
    sfs_phase_t  phase;
    sfs_src_t    src;
    logic [2:0]  bit_cnt;
    logic [5:0]  total;
    logic [7:0]  shreg;
    logic [7:0]  cmd;
    logic [23:0] addr;
  } sfs_link_t;

  typedef struct packed {
    logic       exact;
    logic [7:0] data;
  } sfs_res_t;

  typedef struct packed {
    logic       dout;
    logic       oe_n;
    logic [2:0] obit;
    logic [7:0] sh;
  } sfs_out_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } sfs_sync_t;

endpackage

// ==== design/sfs_status_rw.sv ====
// serial flash command handling: status write, array reads, lock read
`timescale 1ns/1ns
module sfs_status_rw #(
  parameter int ADDR_W       = 20,
  parameter int WRITE_CYCLES = sfs_pkg::SFS_STATUS_WRITE_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              spi_clk,
  input  wire logic              sel_n,
  input  wire logic              serial_in,
  output logic                   serial_out,
  output logic                   serial_out_oe_n,
  input  wire logic              write_protect_n,
  input  wire logic              latch_set,
  input  wire logic              latch_clr,
  input  wire logic              ext_busy,
  output logic [ADDR_W-1:0]      array_addr,
  input  wire logic [7:0]        array_rdata,
  input  wire logic [7:0]        lock_rdata,
  output logic                   write_enable_latch,
  output logic                   busy_flag,
  output logic                   status_write_disable,
  output logic [1:0]             protect_level,
  output logic                   hardware_protected_mode
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sfs_pkg::sfs_core_t core_r;
  sfs_pkg::sfs_core_t core_nxt;
  sfs_pkg::sfs_link_t link_r;
  sfs_pkg::sfs_link_t link_nxt;
  sfs_pkg::sfs_res_t  res_r;
  sfs_pkg::sfs_res_t  res_nxt;
  sfs_pkg::sfs_out_t  out_r;
  sfs_pkg::sfs_out_t  out_nxt;
  sfs_pkg::sfs_sync_t sync_r;
  sfs_pkg::sfs_sync_t sync_nxt;

  logic       sel_rise;
  logic       res_clear;
  logic [7:0] status_byte;
  logic [7:0] shv;
  logic       link_busy;

  localparam sfs_pkg::sfs_core_t CORE_RST = '{
    sel_s1: 1'h1, sel_s2: 1'h1, sel_s3: 1'h1, wp_s1: 1'h1, wp_s2: 1'h1,
    state: sfs_pkg::SFS_IDLE, cnt: 24'h000000, pend_wdis: 1'h0, pend_bp: 2'h0,
    wdis: sfs_pkg::SFS_RST_WDIS, bp: sfs_pkg::SFS_RST_BP, latch: 1'h0,
    wr_busy: 1'h0, busy: 1'h0, hw_prot: 1'h0, res_clr: 1'h0};
  localparam sfs_pkg::sfs_link_t LINK_RST = '{
    phase: sfs_pkg::SFS_PH_CMD, src: sfs_pkg::SFS_SRC_ARRAY, bit_cnt: 3'h0,
    total: 6'h00, shreg: 8'h00, cmd: 8'h00, addr: 24'h000000};
  localparam sfs_pkg::sfs_out_t OUT_RST = '{dout: 1'h0, oe_n: 1'h1, obit: 3'h0, sh: 8'h00};

  // status byte as the core holds it; unused bits stay zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[sfs_pkg::SFS_SR_WDIS]  = core_r.wdis;
    status_byte[sfs_pkg::SFS_SR_PL1]   = core_r.bp[1];
    status_byte[sfs_pkg::SFS_SR_PL0]   = core_r.bp[0];
    status_byte[sfs_pkg::SFS_SR_LATCH] = core_r.latch;
    status_byte[sfs_pkg::SFS_SR_BUSY] = core_r.busy;
  end

  // ----------------------------------------------------------------
  // core domain: protection, status write cycle, latch
  // ----------------------------------------------------------------
  assign sel_rise = core_r.sel_s2 & ~core_r.sel_s3;

  always_comb begin
    core_nxt = core_r;
    core_nxt.sel_s1 = sel_n;
    core_nxt.sel_s2 = core_r.sel_s1;
    core_nxt.sel_s3 = core_r.sel_s2;
    core_nxt.wp_s1  = write_protect_n;
    core_nxt.wp_s2  = core_r.wp_s1;
    // link result is quiet once select is high, so it is safe to read at the rise
    core_nxt.res_clr = sel_rise;
    case (core_r.state)
      sfs_pkg::SFS_IDLE: begin
        if (sel_rise && res_r.exact && core_r.latch && !core_r.hw_prot && !ext_busy) begin
          core_nxt.state     = sfs_pkg::SFS_WRITING;
          core_nxt.wr_busy   = 1'h1;
          core_nxt.cnt       = 24'(WRITE_CYCLES - 1);
          core_nxt.pend_wdis = res_r.data[sfs_pkg::SFS_SR_WDIS];
          core_nxt.pend_bp   = {res_r.data[sfs_pkg::SFS_SR_PL1], res_r.data[sfs_pkg::SFS_SR_PL0]};
        end
      end
      sfs_pkg::SFS_WRITING: begin
        if (core_r.cnt == 24'h000000) begin
          core_nxt.state   = sfs_pkg::SFS_IDLE;
          core_nxt.wr_busy = 1'h0;
          core_nxt.wdis    = core_r.pend_wdis;
          core_nxt.bp      = core_r.pend_bp;
          core_nxt.latch   = 1'h0;
        end else begin
          core_nxt.cnt = core_r.cnt - 24'h000001;
        end
      end
      default: core_nxt.state = sfs_pkg::SFS_IDLE;
    endcase
    if (latch_clr) begin
      core_nxt.latch = 1'h0;
    end
    // a set arriving with a clear keeps the latch set
    if (latch_set) begin
      core_nxt.latch = 1'h1;
    end
    core_nxt.busy = core_nxt.wr_busy | ext_busy;
    // level term: entered in either order, left by the pin going high or by a status write that ends with wdis clear
    core_nxt.hw_prot = core_nxt.wdis & ~core_r.wp_s2;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_r <= CORE_RST;
    end else begin
      core_r <= core_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status into the link domain, bitwise two-flop; bits change rarely
  // ----------------------------------------------------------------
  always_comb begin
    sync_nxt    = sync_r;
    sync_nxt.s1 = status_byte;
    sync_nxt.s2 = sync_r.s1;
  end

  always_ff @(posedge spi_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign link_busy = sync_r.s2[sfs_pkg::SFS_SR_BUSY];

  // ----------------------------------------------------------------
  // link domain: command shifter on rising edges
  // ----------------------------------------------------------------
  always_comb begin
    link_nxt = link_r;
    shv = {link_r.shreg[6:0], serial_in};
    link_nxt.shreg   = shv;
    link_nxt.bit_cnt = link_r.bit_cnt + 3'h1;
    if (link_r.total != sfs_pkg::SFS_TOTAL_MAX) begin
      link_nxt.total = link_r.total + 6'h01;
    end
    case (link_r.phase)
      sfs_pkg::SFS_PH_CMD: begin
        if (link_r.bit_cnt == sfs_pkg::SFS_BYTE_LAST) begin
          link_nxt.cmd = shv;
          if (shv == sfs_pkg::SFS_CMD_WRITE_STATUS) begin
            link_nxt.phase = sfs_pkg::SFS_PH_WDATA;
          end else if (shv == sfs_pkg::SFS_CMD_READ_STATUS) begin
            link_nxt.phase = sfs_pkg::SFS_PH_DATA;
            link_nxt.src   = sfs_pkg::SFS_SRC_STATUS;
          end else if (shv == sfs_pkg::SFS_CMD_READ || shv == sfs_pkg::SFS_CMD_FAST_READ ||
                       shv == sfs_pkg::SFS_CMD_LOCK_READ) begin
            link_nxt.phase = link_busy ? sfs_pkg::SFS_PH_IGNORE : sfs_pkg::SFS_PH_ADDR;
          end else begin
            link_nxt.phase = sfs_pkg::SFS_PH_IGNORE;
          end
        end
      end
      sfs_pkg::SFS_PH_ADDR: begin
        link_nxt.addr = {link_r.addr[22:0], serial_in};
        if (link_r.total == sfs_pkg::SFS_ADDR_LAST_BIT) begin
          link_nxt.src   = (link_r.cmd == sfs_pkg::SFS_CMD_LOCK_READ) ? sfs_pkg::SFS_SRC_LOCK
                                                                       : sfs_pkg::SFS_SRC_ARRAY;
          link_nxt.phase = (link_r.cmd == sfs_pkg::SFS_CMD_FAST_READ) ? sfs_pkg::SFS_PH_DUMMY
                                                                       : sfs_pkg::SFS_PH_DATA;
        end
      end
      sfs_pkg::SFS_PH_DUMMY: begin
        if (link_r.bit_cnt == sfs_pkg::SFS_BYTE_LAST) begin
          link_nxt.phase = sfs_pkg::SFS_PH_DATA;
        end
      end
      sfs_pkg::SFS_PH_DATA: begin
        // lock byte repeats for the same sector; array address walks and wraps
        if (link_r.bit_cnt == sfs_pkg::SFS_BYTE_LAST && link_r.src == sfs_pkg::SFS_SRC_ARRAY) begin
          link_nxt.addr = link_r.addr + 24'h000001;
        end
      end
      default: begin
        link_nxt.phase = link_r.phase;
      end
    endcase
  end

  // select high holds the shifter idle, so every frame starts from command bit 0
  always_ff @(posedge spi_clk or posedge sel_n) begin
    if (sel_n) begin
      link_r <= LINK_RST;
    end else begin
      link_r <= link_nxt;
    end
  end

  // only the low address bits reach the array, wrapping at its top
  assign array_addr = link_r.addr[ADDR_W-1:0];

  // ----------------------------------------------------------------
  // status write frame result, held across the select rise
  // ----------------------------------------------------------------
  always_comb begin
    res_nxt = res_r;
    // true only when the frame stopped right after the eighth data bit
    res_nxt.exact = (link_r.phase == sfs_pkg::SFS_PH_WDATA) &&
                    (link_r.total == sfs_pkg::SFS_WSR_LAST_BIT);
    if (res_nxt.exact) begin
      res_nxt.data = shv;
    end
  end

  // cleared from the core after use so a clockless frame cannot replay it
  assign res_clear = ~reset_n | core_r.res_clr;

  always_ff @(posedge spi_clk or posedge res_clear) begin
    if (res_clear) begin
      res_r <= '0;
    end else begin
      res_r <= res_nxt;
    end
  end

  // ----------------------------------------------------------------
  // link domain: data out on falling edges
  // ----------------------------------------------------------------
  always_comb begin
    out_nxt = out_r;
    if (link_r.phase == sfs_pkg::SFS_PH_DATA) begin
      out_nxt.oe_n = 1'h0;
      out_nxt.obit = out_r.obit + 3'h1;
      if (out_r.obit == 3'h0) begin
        case (link_r.src)
          sfs_pkg::SFS_SRC_LOCK:   out_nxt.sh = lock_rdata;
          sfs_pkg::SFS_SRC_STATUS: out_nxt.sh = sync_r.s2 & sfs_pkg::SFS_SR_READ_MASK;
          default:                 out_nxt.sh = array_rdata;
        endcase
      end else begin
        out_nxt.sh = {out_r.sh[6:0], 1'h0};
      end
      out_nxt.dout = out_nxt.sh[7];
    end
  end

  always_ff @(negedge spi_clk or posedge sel_n) begin
    if (sel_n) begin
      out_r <= OUT_RST;
    end else begin
      out_r <= out_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign serial_out              = out_r.dout;
  assign serial_out_oe_n         = out_r.oe_n;
  assign write_enable_latch      = core_r.latch;
  assign busy_flag               = core_r.busy;
  assign status_write_disable    = core_r.wdis;
  assign protect_level           = core_r.bp;
  assign hardware_protected_mode = core_r.hw_prot;

endmodule // sfs_status_rw

// ==== verif/sfs_host.sv ====
// spi host model driving the serial flash block
`timescale 1ns/1ns
module sfs_host (
  output logic     spi_clk,
  output logic     sel_n,
  output logic     serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  // ------
  // frame
  // ------
  initial begin
    spi_clk = 1'b0;
    sel_n = 1'b1;
    serial_in = 1'b0;
  end
  // serial clock runs only inside a frame; tx sent msb first from bit 63
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                       output logic [31:0] rx, output logic drove);
    rx = 32'h0;
    drove = 1'b0;
    sel_n = 1'b0;
    #6;
    for (int i = 0; i < ntx; i++) begin
      serial_in = tx[63-i];
      #6 spi_clk = 1'b1;
      #6 spi_clk = 1'b0;
    end
    for (int i = 0; i < nrx; i++) begin
      serial_in = ~serial_in;
      #6 spi_clk = 1'b1;
      rx = {rx[30:0], serial_out};
      drove = drove | !serial_out_oe_n;
      #6 spi_clk = 1'b0;
    end
    #6 sel_n = 1'b1;
    serial_in = ~serial_in;
    #250;
  endtask
endmodule // sfs_host

// ==== verif/sfs_status_rw_asserts.sv ====
// checker for the serial flash status write and read block
`timescale 1ns/1ns
module sfs_status_rw_asserts #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       sel_n,
  input wire logic       serial_out_oe_n,
  input wire logic       write_protect_n,
  input wire logic       latch_set,
  input wire logic       latch_clr,
  input wire logic       ext_busy,
  input wire logic       write_enable_latch,
  input wire logic       busy_flag,
  input wire logic       status_write_disable,
  input wire logic [1:0] protect_level,
  input wire logic       hardware_protected_mode
);
  // ------
  // busy run length, counted since the cycle is far beyond a repetition
  // ------
  int run_len_r;
  int run_len_nxt;
  always_comb run_len_nxt = busy_flag ? run_len_r + 1 : 0;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_len_r <= 0;
    end else begin
      run_len_r <= run_len_nxt;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_OE_RELEASED: assert property (sel_n && $past(sel_n) |-> serial_out_oe_n)
    else $error("serial out enabled while deselected");
  AST_BITS_AT_END: assert property ($changed({status_write_disable, protect_level}) |->
    $past(busy_flag) && !write_enable_latch) else $error("protect bits changed outside cycle end");
  AST_BUSY_SPAN: assert property ($fell(busy_flag) && $fell(write_enable_latch) |->
    run_len_r == WRITE_CYCLES) else $error("status write cycle length wrong");
  AST_LATCH_FALL: assert property ($fell(write_enable_latch) |-> $past(latch_clr) || $fell(busy_flag))
    else $error("latch cleared without cause");
  AST_LATCH_SET: assert property (latch_set |=> write_enable_latch)
    else $error("latch not set");
  AST_HPM_ENTER: assert property ((status_write_disable && !write_protect_n) [*4] |->
    hardware_protected_mode) else $error("hardware protection not entered");
  AST_HPM_LEAVE: assert property (write_protect_n [*4] |-> !hardware_protected_mode)
    else $error("hardware protection kept with pin high");
  AST_HPM_CAUSE: assert property (hardware_protected_mode |-> status_write_disable)
    else $error("hardware protection without write disable");
  AST_BUSY_EXT: assert property (ext_busy |=> busy_flag)
    else $error("busy not shown for external cycle");
  cover property ($rose(busy_flag) && !ext_busy);
  cover property ($rose(hardware_protected_mode));
  cover property ($fell(serial_out_oe_n));
endmodule // sfs_status_rw_asserts

bind sfs_status_rw sfs_status_rw_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_sfs_chk (
  .clk(clk), .reset_n(reset_n), .sel_n(sel_n), .serial_out_oe_n(serial_out_oe_n),
  .write_protect_n(write_protect_n), .latch_set(latch_set), .latch_clr(latch_clr), .ext_busy(ext_busy),
  .write_enable_latch(write_enable_latch), .busy_flag(busy_flag), .status_write_disable(status_write_disable),
  .protect_level(protect_level), .hardware_protected_mode(hardware_protected_mode));

// ==== verif/sfs_status_rw_tb.sv ====
// testbench for the serial flash status write and read block
`timescale 1ns/1ns
module sfs_status_rw_tb;
  localparam int WC = 20;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        write_protect_n = 1'b1;
  logic        latch_set = 1'b0;
  logic        latch_clr = 1'b0;
  logic        ext_busy = 1'b0;
  logic        spi_clk, sel_n, serial_in, serial_out, serial_out_oe_n;
  logic [19:0] array_addr;
  logic [7:0]  array_rdata, lock_rdata;
  logic        latch, busy, wdis, hw_prot, dr;
  logic [1:0]  bp;
  logic [31:0] rx;
  int          error_cnt = 0;
  int          num_checks = 0;
  // ------
  // harness
  // ------
  assign array_rdata = array_addr[7:0] ^ 8'hA5;
  assign lock_rdata = {4'h3, array_addr[19:16]};
  always #25 clk = ~clk;
  sfs_host u_host (.spi_clk(spi_clk), .sel_n(sel_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n));
  sfs_status_rw #(.ADDR_W(20), .WRITE_CYCLES(WC)) DUT (.clk(clk), .reset_n(reset_n), .spi_clk(spi_clk),
    .sel_n(sel_n), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .write_protect_n(write_protect_n), .latch_set(latch_set), .latch_clr(latch_clr), .ext_busy(ext_busy),
    .array_addr(array_addr), .array_rdata(array_rdata), .lock_rdata(lock_rdata), .write_enable_latch(latch),
    .busy_flag(busy), .status_write_disable(wdis), .protect_level(bp), .hardware_protected_mode(hw_prot));
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wait_busy(input logic v, input int lim);
    for (int i = 0; i < lim && busy !== v; i++) @(posedge clk);
  endtask
  task pulse(input logic clr);
    @(posedge clk);
    if (clr) latch_clr <= 1'b1;
    else latch_set <= 1'b1;
    @(posedge clk) {latch_set, latch_clr} <= 2'h0;
    @(posedge clk);
  endtask
  task wsr(input logic [7:0] d);
    u_host.frame({8'h01, d, 48'h0}, 16, 0, rx, dr);
    wait_busy(1'b1, 10);
  endtask
  task sr_read;
    u_host.frame({8'h05, 56'h0}, 8, 8, rx, dr);
  endtask
  task wp_set(input logic v);
    @(posedge clk) write_protect_n <= v;
    repeat (5) @(posedge clk);
  endtask
  // ------
  // scenarios
  // ------
  task t_reset_vals;
    check({latch, busy, wdis, bp, hw_prot}, 32'h0);
    sr_read;
    check(rx, 32'h0);
  endtask
  task t_no_latch;
    pulse(1'b0);
    pulse(1'b1);
    check(latch, 32'h0);
    wsr(8'h8C);
    check({busy, wdis, bp}, 32'h0);
  endtask
  task t_bad_len;
    pulse(1'b0);
    u_host.frame({8'h01, 8'h8C, 48'h0}, 15, 0, rx, dr);
    wait_busy(1'b1, 10);
    check(busy, 32'h0);
    u_host.frame({8'h01, 8'h8C, 48'h0}, 17, 0, rx, dr);
    wait_busy(1'b1, 10);
    check({busy, wdis, bp}, 32'h0);
  endtask
  task t_wsr_ok;
    wsr(8'hFF);
    check(busy, 32'h1);
    sr_read;
    check(rx, 32'h03);
    wait_busy(1'b0, WC + 10);
    check({wdis, bp}, 32'h7);
    check(latch, 32'h0);
    sr_read;
    check(rx, 32'h8C);
  endtask
  task t_hpm;
    wp_set(1'b0);
    check(hw_prot, 32'h1);
    pulse(1'b0);
    wsr(8'h00);
    check(busy, 32'h0);
    check({wdis, bp}, 32'h7);
    wp_set(1'b1);
    check(hw_prot, 32'h0);
    wsr(8'h00);
    wait_busy(1'b0, WC + 10);
    check({wdis, bp}, 32'h0);
    wp_set(1'b0);
    pulse(1'b0);
    wsr(8'h80);
    wait_busy(1'b0, WC + 10);
    repeat (5) @(posedge clk);
    check(hw_prot, 32'h1);
    wp_set(1'b1);
  endtask
  task t_reads;
    u_host.frame({8'h03, 24'hFFFFFE, 32'h0}, 32, 32, rx, dr);
    check(rx, 32'h5B5AA5A4);
    repeat (2) @(posedge clk);
    check(serial_out_oe_n, 32'h1);
    u_host.frame({8'h0B, 24'h012345, 32'h0}, 40, 16, rx, dr);
    check(rx, 32'hE0E3);
    u_host.frame({8'hE8, 24'h07ABCD, 32'h0}, 32, 16, rx, dr);
    check(rx, 32'h3737);
  endtask
  task t_busy_reject;
    @(posedge clk) ext_busy <= 1'b1;
    repeat (3) @(posedge clk);
    check(busy, 32'h1);
    u_host.frame({8'h03, 24'h000010, 32'h0}, 32, 8, rx, dr);
    check(dr, 32'h0);
    u_host.frame({8'hE8, 24'h000010, 32'h0}, 32, 8, rx, dr);
    check(dr, 32'h0);
    sr_read;
    check(rx, 32'h81);
    @(posedge clk) ext_busy <= 1'b0;
    wait_busy(1'b0, 5);
    check(busy, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_vals;
    t_no_latch;
    t_bad_len;
    t_wsr_ok;
    t_hpm;
    t_reads;
    t_busy_reject;
    print_verdict;
  end
  initial begin
    #100000;
    error_cnt++;
    print_verdict;
  end
endmodule // sfs_status_rw_tb
